/* core/wbc_regs.vh */
// Constants for the waveform burst controller: sources, widths, timing.
// Assumes a 100 MHz clock and a phase accumulator supplied by the surrounding generator.
`ifndef WBC_REGS_VH
`define WBC_REGS_VH

// --------------------------------------------------------------
// Field widths
// --------------------------------------------------------------
`define WBC_PHASE_W      32
`define WBC_COUNT_W      20
`define WBC_DELAY_W      40
`define WBC_COUNT_MAX    20'hF_4240
`define WBC_COUNT_MIN    20'h0_0001

// --------------------------------------------------------------
// Trigger source codes
// --------------------------------------------------------------
`define WBC_SRC_EXT      2'h0
`define WBC_SRC_TIMER    2'h1
`define WBC_SRC_KEY      2'h2
`define WBC_SRC_REMOTE   2'h3

// --------------------------------------------------------------
// Timing: delay granularity and length of trigger-out pulse
// --------------------------------------------------------------
`define WBC_DELAY_STEP_PS 100
`define WBC_CLK_PERIOD_PS 10000
`define WBC_DELAY_STEPS_PER_CLK (`WBC_CLK_PERIOD_PS / `WBC_DELAY_STEP_PS)
`define WBC_DELAY_MAX_S  85
`define WBC_TOUT_LEN     4'h4

`endif

/* core/wbc_delay_timer.v */
// Trigger delay timer: counts a programmed interval in 100 ps units.
// Assumes clk at 100 MHz, so each clock subtracts one period's worth of steps.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_regs.vh"

module wbc_delay_timer
(
   input  wire                     clk,       // System clock
   input  wire                     reset_n,   // Async reset, active low
   input  wire                     clk_en,    // Freezes state when low
   input  wire                     start,     // Load and begin timing
   input  wire [`WBC_DELAY_W-1:0]  delay,     // Interval in 100 ps steps
   output wire                     busy,      // Timing in progress
   output reg                      done       // One-cycle pulse at expiry
);

   // --------------------------------------------------------------
   // Remaining steps
   // --------------------------------------------------------------
   reg  [`WBC_DELAY_W-1:0] left_r;          // Steps still to wait
   reg                     run_r;           // Counting
   localparam [`WBC_DELAY_W-1:0] STEP = `WBC_DELAY_STEPS_PER_CLK;

   assign busy = run_r;

   // Countdown; resolution below one clock is rounded up to whole clocks
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         left_r <= {`WBC_DELAY_W{1'b0}};
         run_r  <= 1'b0;
         done   <= 1'b0;
      end
      else if (clk_en)
      begin
         done <= 1'b0;
         if (start)
         begin
            left_r <= delay;
            run_r  <= 1'b1;
         end
         else if (run_r)
         begin
            // Expire once the remainder fits in one clock
            if (left_r <= STEP)
            begin
               run_r <= 1'b0;
               done  <= 1'b1;
            end
            else
               left_r <= left_r - STEP;
         end
      end
   end

endmodule // wbc_delay_timer
`default_nettype wire

/* core/wbc_burst_ctrl.v */
// Burst controller: trigger selection, delay, counted and gated bursts.
// Assumes an external phase accumulator reports its phase and accepts
// run and restart-load controls from this block.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_regs.vh"

module wbc_burst_ctrl
(
   input  wire                     clk,           // System clock
   input  wire                     reset_n,       // Async reset, active low
   input  wire                     clk_en,        // Freezes state when low
   input  wire                     burst_en,      // Burst function on
   input  wire                     gated_mode,    // 1 gated, 0 counted
   input  wire                     count_inf,     // Infinite burst count
   input  wire [`WBC_COUNT_W-1:0]  burst_count,   // Cycles per burst
   input  wire [1:0]               trig_src,      // Trigger source select
   input  wire                     ext_edge_fall, // 0 rising, 1 falling edge
   input  wire                     gate_pol_low,  // Gate true when pin low
   input  wire                     trig_out_en,   // Drive pin as trigger out
   input  wire                     tout_pol_fall, // 0 rising pulse, 1 falling
   input  wire [`WBC_DELAY_W-1:0]  trig_delay,    // Delay in 100 ps steps
   input  wire [15:0]              start_phase,   // Degrees scaled: 0..65535
   input  wire                     noise_sel,     // Noise waveform active
   input  wire                     timer_tick,    // Internal timer trigger
   input  wire                     key_trig,      // Manual key trigger
   input  wire                     remote_trig,   // Remote command trigger
   input  wire                     trig_pin_in,   // Trigger pin level
   output reg                      trig_pin_out,  // Trigger pin drive level
   output reg                      trig_pin_oe,   // Trigger pin drive enable
   input  wire [`WBC_PHASE_W-1:0]  acc_phase,     // Current accumulator phase
   input  wire                     acc_wrap,      // Accumulator crossed record end
   output reg                      acc_run,       // Accumulator advancing
   output reg                      acc_load,      // Load start phase pulse
   output reg  [`WBC_PHASE_W-1:0]  acc_load_val,  // Start phase as record point
   output reg  [`WBC_COUNT_W-1:0]  cycles_done,   // Cycles in current burst
   output wire                     burst_busy     // Burst or delay active
);

   // --------------------------------------------------------------
   // States, one-hot
   // --------------------------------------------------------------
   localparam [3:0] ST_IDLE  = 4'b0001;   // Waiting for trigger or gate
   localparam [3:0] ST_DELAY = 4'b0010;   // Trigger delay running
   localparam [3:0] ST_RUN   = 4'b0100;   // Emitting cycles
   localparam [3:0] ST_DRAIN = 4'b1000;   // Gate off, finishing cycle

   reg  [3:0]               state_r;       // Current state
   reg                      pin_d_r;       // Previous pin level for edges
   reg  [3:0]               tout_cnt_r;    // Trigger-out pulse length
   reg  [`WBC_PHASE_W-1:0]  prev_phase_r;  // Phase one clock ago
   wire                     dly_done;      // Delay expired
   wire                     ext_edge;      // Selected edge on pin
   wire                     trig_any;      // Trigger from selected source
   wire                     gate_true;     // Gate level true
   wire [`WBC_PHASE_W-1:0]  sp_point;      // Start phase as record point
   wire                     at_start;      // Accumulator crossed start phase
   wire                     count_hit;     // Final cycle completed

   // --------------------------------------------------------------
   // Trigger sources and gate level
   // --------------------------------------------------------------
   // Pin is only an input while trigger out is off
   assign ext_edge  = !trig_out_en &&
                      (ext_edge_fall ? (pin_d_r && !trig_pin_in)
                                     : (!pin_d_r && trig_pin_in));
   assign trig_any  = (trig_src == `WBC_SRC_EXT)   ? ext_edge :
                      (trig_src == `WBC_SRC_TIMER) ? timer_tick :
                      (trig_src == `WBC_SRC_KEY)   ? key_trig :
                                                     remote_trig;
   // Level, not edge, steers gated mode
   assign gate_true = !trig_out_en && (trig_pin_in ^ gate_pol_low);

   // --------------------------------------------------------------
   // Start phase mapping and crossing detection
   // --------------------------------------------------------------
   // Linear map: 0 is first point, full scale is end of record
   assign sp_point = {start_phase, 16'h0000};
   // A cycle ends when phase passes the start point, including wraps
   assign at_start = acc_wrap
                   ? ((prev_phase_r < sp_point) || (acc_phase >= sp_point))
                   : ((prev_phase_r < sp_point) && (acc_phase >= sp_point));
   assign count_hit = !count_inf && (cycles_done + 20'h0_0001 >= burst_count);
   assign burst_busy = !state_r[0];

   // --------------------------------------------------------------
   // Delay timer
   // --------------------------------------------------------------
   wbc_delay_timer wbc_delay_timer_inst
   (
      .clk     (clk),
      .reset_n (reset_n),
      .clk_en  (clk_en),
      .start   (state_r[0] && burst_en && !gated_mode && trig_any),
      .delay   (trig_delay),
      .busy    (),          // Unused: the delay state already tracks it
      .done    (dly_done)
   );

   // --------------------------------------------------------------
   // Main sequencer
   // --------------------------------------------------------------
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_r      <= ST_IDLE;
         pin_d_r      <= 1'b0;
         prev_phase_r <= {`WBC_PHASE_W{1'b0}};
         acc_run      <= 1'b0;
         acc_load     <= 1'b0;
         acc_load_val <= {`WBC_PHASE_W{1'b0}};
         cycles_done  <= {`WBC_COUNT_W{1'b0}};
      end
      else if (clk_en)
      begin
         pin_d_r      <= trig_pin_in;
         // A load makes the accumulator jump to the start point; taking the
         // old phase here would count that jump as a false crossing
         if (acc_load)
            prev_phase_r <= acc_load_val;
         else
            prev_phase_r <= acc_phase;
         acc_load     <= 1'b0;
         acc_load_val <= sp_point;
         case (state_r)
            ST_IDLE:
            begin
               // Output parked at start phase sample
               acc_run <= 1'b0;
               if (burst_en && gated_mode && gate_true)
               begin
                  acc_load <= 1'b1;
                  acc_run  <= 1'b1;
                  state_r  <= ST_RUN;
               end
               else if (burst_en && !gated_mode && trig_any)
                  state_r <= ST_DELAY;
            end
            ST_DELAY:
            begin
               // Further triggers fall through unseen here
               if (dly_done)
               begin
                  // Realign to start phase on each trigger
                  acc_load    <= 1'b1;
                  acc_run     <= 1'b1;
                  cycles_done <= {`WBC_COUNT_W{1'b0}};
                  state_r     <= ST_RUN;
               end
               else if (!burst_en)
                  state_r <= ST_IDLE;
            end
            ST_RUN:
            begin
               if (!burst_en)
               begin
                  acc_run <= 1'b0;
                  state_r <= ST_IDLE;
               end
               else if (gated_mode)
               begin
                  if (!gate_true && noise_sel)
                  begin
                     // Noise has no cycle; cut at once
                     acc_run <= 1'b0;
                     state_r <= ST_IDLE;
                  end
                  else if (!gate_true)
                     state_r <= ST_DRAIN;
               end
               else if (at_start && !acc_load)
               begin
                  // Infinite count never stops
                  if (count_hit)
                  begin
                     acc_run     <= 1'b0;
                     // Final cycle counts too, so the total reads back whole
                     cycles_done <= cycles_done + 20'h0_0001;
                     acc_load    <= 1'b1;
                     state_r     <= ST_IDLE;
                  end
                  else if (!count_inf)
                     cycles_done <= cycles_done + 20'h0_0001;
               end
            end
            ST_DRAIN:
            begin
               // Gate returning true mid-drain resumes the run
               if (gate_true && burst_en)
                  state_r <= ST_RUN;
               else if (at_start || !burst_en)
               begin
                  acc_run  <= 1'b0;
                  acc_load <= 1'b1;
                  state_r  <= ST_IDLE;
               end
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   // --------------------------------------------------------------
   // Trigger output pulse on the shared pin
   // --------------------------------------------------------------
   // Pulse marks the internal trigger moment, before any delay
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         tout_cnt_r   <= 4'h0;
         trig_pin_oe  <= 1'b0;
         trig_pin_out <= 1'b0;
      end
      else if (clk_en)
      begin
         trig_pin_oe <= trig_out_en;
         if (trig_out_en && state_r[0] && burst_en && !gated_mode && trig_any)
            tout_cnt_r <= `WBC_TOUT_LEN;
         else if (tout_cnt_r != 4'h0)
            tout_cnt_r <= tout_cnt_r - 4'h1;
         // Idle level opposite to pulse polarity
         trig_pin_out <= (tout_cnt_r != 4'h0) ^ tout_pol_fall;
      end
   end

endmodule // wbc_burst_ctrl
`default_nettype wire

/* dv/wbc_acc_model.sv */
// Phase accumulator model facing the burst controller.
// Assumes one clock; steps STEP per clock while run is high.
`timescale 1ns/100ps
`default_nettype none
module wbc_acc_model #(parameter logic [31:0] STEP = 32'h2000_0000)
(
   input  wire logic        clk,      // System clock
   input  wire logic        reset_n,  // Async reset, active low
   input  wire logic        run,      // Advance request
   input  wire logic        load,     // Load request
   input  wire logic [31:0] load_val, // Start point
   output var  logic [31:0] phase,    // Current phase
   output var  logic        wrap      // Crossed record end
);
   // ------------------------------
   // Accumulator
   // ------------------------------
   // Load beats step, so a restart never skips the start point
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         {wrap, phase} <= 33'h0_0000_0000;
      else if (load)
         {wrap, phase} <= {1'b0, load_val}; // Realign on restart
      else if (run)
         {wrap, phase} <= {1'b0, phase} + {1'b0, STEP}; // Carry out is the wrap
      else
         wrap <= 1'b0; // Stopped: phase holds
   end
endmodule // wbc_acc_model
`default_nettype wire

/* dv/wbc_burst_ctrl_properties.sv */
// Port-level assertions for the burst controller.
// Assumes it is bound into wbc_burst_ctrl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_regs.vh"
module wbc_burst_chk
(
   input wire logic                    clk,
   input wire logic                    reset_n,
   input wire logic                    clk_en,
   input wire logic                    burst_en,
   input wire logic                    gated_mode,
   input wire logic                    gate_pol_low,
   input wire logic                    trig_out_en,
   input wire logic                    tout_pol_fall,
   input wire logic [15:0]             start_phase,
   input wire logic                    noise_sel,
   input wire logic                    trig_pin_in,
   input wire logic                    trig_pin_out,
   input wire logic                    trig_pin_oe,
   input wire logic                    acc_run,
   input wire logic                    acc_load,
   input wire logic [`WBC_PHASE_W-1:0] acc_load_val,
   input wire logic                    burst_busy
);
   // ------------------------------
   // Shared clock, reset, gate level
   // ------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   wire gate_true = trig_pin_in ^ gate_pol_low; // Gate after polarity
   property p_load_val; acc_load |-> acc_load_val == {$past(start_phase), 16'h0000}; endproperty
   a_load_val: assert property (p_load_val) else $error("bad load point");
   property p_oe; $rose(trig_out_en) |=> trig_pin_oe; endproperty
   a_oe: assert property (p_oe) else $error("pin not driven");
   property p_tout;
      $rose(trig_pin_out) && trig_pin_oe && !tout_pol_fall |-> trig_pin_out [*4] ##1 !trig_pin_out;
   endproperty
   a_tout: assert property (p_tout) else $error("bad trigger out pulse");
   property p_cnt_start; $rose(acc_run) && !gated_mode |-> $past(burst_busy); endproperty
   a_cnt_start: assert property (p_cnt_start) else $error("start without trigger");
   property p_start_load; $rose(acc_run) |-> acc_load; endproperty
   a_start_load: assert property (p_start_load) else $error("start not aligned");
   property p_stop_load; $fell(acc_run) && !noise_sel |-> acc_load; endproperty
   a_stop_load: assert property (p_stop_load) else $error("stop not aligned");
   property p_gate_on;
      gated_mode && burst_en && clk_en && !trig_out_en && !burst_busy && gate_true
         |=> acc_run && acc_load;
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("gate ignored");
   property p_noise_stop;
      gated_mode && noise_sel && clk_en && !trig_out_en && acc_run && !gate_true |=> !acc_run;
   endproperty
   a_noise_stop: assert property (p_noise_stop) else $error("noise kept running");
   // Low enable must freeze run and pin alike
   property p_freeze; !clk_en |=> $stable(acc_run) && $stable(trig_pin_out); endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while frozen");
   c_counted_end: cover property ($fell(acc_run) && !gated_mode);
   c_gated_end: cover property ($fell(acc_run) && gated_mode);
   c_tout: cover property ($rose(trig_pin_out) && trig_pin_oe);
endmodule // wbc_burst_chk
bind wbc_burst_ctrl wbc_burst_chk wbc_burst_chk_inst
(
   .clk, .reset_n, .clk_en, .burst_en, .gated_mode, .gate_pol_low, .trig_out_en,
   .tout_pol_fall, .start_phase, .noise_sel, .trig_pin_in, .trig_pin_out,
   .trig_pin_oe, .acc_run, .acc_load, .acc_load_val, .burst_busy
);
`default_nettype wire

/* dv/wbc_burst_ctrl_test.sv */
// Self-checking bench for the burst controller with a phase model.
// Assumes the controller header is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "wbc_regs.vh"
module wbc_burst_ctrl_test;
   localparam int PER = 8; // Clocks per waveform cycle at the model step
   logic                    clk, reset_n, clk_en, burst_en, gated_mode, count_inf;
   logic                    ext_edge_fall, gate_pol_low, trig_out_en, tout_pol_fall;
   logic                    noise_sel, timer_tick, key_trig, remote_trig, trig_pin_in;
   logic [`WBC_COUNT_W-1:0] burst_count;
   logic [1:0]              trig_src;
   logic [`WBC_DELAY_W-1:0] trig_delay;
   logic [15:0]             start_phase;
   wire  [`WBC_PHASE_W-1:0] acc_phase, acc_load_val;
   wire  [`WBC_COUNT_W-1:0] cycles_done;
   wire                     acc_wrap, trig_pin_out, trig_pin_oe, acc_run, acc_load, burst_busy;
   int                      n_errors = 0, num_checks = 0, lat, len, hi;
   // Rows: source, count, delay, phase, then expected delay in clocks
   logic [1:0]              r_src [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [19:0]             r_cnt [4] = '{20'h0_0001, 20'h0_0003, 20'h0_0002, 20'h0_0005};
   logic [39:0]             r_dly [4] = '{40'h00_0000_0000, 40'h00_0000_07d0,
                                          40'h00_0000_0000, 40'h00_0000_01f4};
   logic [15:0]             r_ph  [4] = '{16'h0000, 16'h4000, 16'hc000, 16'h0000};
   int                      r_wait [4] = '{1, 20, 1, 5};
   wbc_burst_ctrl wbc_burst_ctrl_inst
   (
      .clk, .reset_n, .clk_en, .burst_en, .gated_mode, .count_inf, .burst_count,
      .trig_src, .ext_edge_fall, .gate_pol_low, .trig_out_en, .tout_pol_fall,
      .trig_delay, .start_phase, .noise_sel, .timer_tick, .key_trig, .remote_trig,
      .trig_pin_in, .trig_pin_out, .trig_pin_oe, .acc_phase, .acc_wrap, .acc_run,
      .acc_load, .acc_load_val, .cycles_done, .burst_busy
   );
   wbc_acc_model wbc_acc_model_inst
   (
      .clk, .reset_n, .run(acc_run), .load(acc_load), .load_val(acc_load_val),
      .phase(acc_phase), .wrap(acc_wrap)
   );
   // ------------------------------
   // Clock, helpers, verdict
   // ------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task tick(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task chk(input string what, input logic [63:0] lo, hi_b, got);
      num_checks++;
      if ((got >= lo && got <= hi_b) !== 1'b1)
      begin
         n_errors++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi_b, got);
      end
   endtask
   // One-clock pulse on the chosen source
   task fire(input logic [1:0] s);
      {trig_pin_in, timer_tick, key_trig, remote_trig} = 4'b1000 >> s;
      tick();
      {trig_pin_in, timer_tick, key_trig, remote_trig} = 4'h0;
   endtask
   // Trigger, time the start, time the run, retrigger mid-run
   task burst(input logic [1:0] s);
      lat = 0;
      len = 0;
      fire(s);
      while (acc_run !== 1'b1 && lat < 3000)
      begin
         tick();
         lat++;
      end
      while (acc_run === 1'b1 && len < 3000)
      begin
         if (len == 3)
            fire(s); // Busy: this one must be dropped
         else
            tick();
         len++;
      end
   endtask
   task idle_wait;
      for (int i = 0; i < 3000 && burst_busy !== 1'b0; i++)
         tick();
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Tests need well under a thousand clocks; 50k is ample margin
   initial
   begin
      #500_000;
      n_errors++;
      close_out();
   end
   initial
   begin
      {clk_en, burst_en, gated_mode, count_inf, ext_edge_fall, gate_pol_low} = 6'h30;
      {trig_out_en, tout_pol_fall, noise_sel, timer_tick, key_trig, remote_trig} = 6'h00;
      {trig_pin_in, reset_n, trig_src, start_phase} = 20'h0_0000;
      {burst_count, trig_delay} = 60'h0_0001_00_0000_0000;
      tick(20);
      chk("reset outs", 0, 0, {acc_run, acc_load, trig_pin_out, trig_pin_oe, burst_busy});
      reset_n = 1'b1;
      tick(20);
      chk("idle run", 0, 0, {acc_run, burst_busy});
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         {trig_src, burst_count, trig_delay, start_phase} =
            {r_src[i], r_cnt[i], r_dly[i], r_ph[i]};
         tick();
         burst(r_src[i]);
         chk("start delay", r_wait[i] + 1, r_wait[i] + 4, lat);
         chk("run length", PER * r_cnt[i], PER * r_cnt[i] + 3, len);
         chk("cycle count", r_cnt[i], r_cnt[i], cycles_done);
         chk("load point", {r_ph[i], 16'h0000}, {r_ph[i], 16'h0000}, acc_load_val);
         tick(30);
         chk("retrigger", 0, 0, {acc_run, burst_busy});
         $display("row %0d done", i);
      end
      {ext_edge_fall, trig_src, trig_pin_in} = 4'b1001;
      tick(5);
      chk("rise ignored", 0, 0, burst_busy);
      trig_pin_in = 1'b0;
      tick(3);
      chk("fall taken", 1, 1, burst_busy);
      idle_wait();
      {ext_edge_fall, count_inf, trig_src} = 4'b0110;
      fire(2'h2);
      tick(200);
      chk("infinite run", 1, 1, acc_run);
      reset_n = 1'b0;
      tick();
      chk("reset stop", 0, 0, acc_run);
      // Release into gated mode with the infinite count off again
      {reset_n, count_inf, gated_mode, start_phase} = 19'h5_0000;
      $display("test edge and infinite done");
      trig_pin_in = 1'b1;
      tick(2);
      chk("gate on", 1, 1, acc_run);
      tick(19);
      chk("gate steady", 1, 1, acc_run);
      trig_pin_in = 1'b0;
      tick();
      chk("cycle finish", 1, 1, acc_run);
      for (hi = 0; hi < 20 && acc_run !== 1'b0; hi++)
         tick();
      tick(2);
      chk("hold point", 0, 0, acc_phase);
      {noise_sel, trig_pin_in} = 2'b11;
      tick(5);
      trig_pin_in = 1'b0;
      tick(2);
      chk("noise stop", 0, 0, acc_run);
      {noise_sel, gated_mode, trig_out_en, trig_src} = 5'b00110;
      $display("test gated done");
      fire(2'h2);
      hi = 0;
      repeat (12)
      begin
         hi += (trig_pin_out === 1'b1);
         tick();
      end
      chk("pulse width", `WBC_TOUT_LEN, `WBC_TOUT_LEN, hi);
      chk("pin driven", 1, 1, trig_pin_oe);
      clk_en = 1'b0;
      tick(3);
      chk("frozen run", 1, 1, acc_run);
      clk_en = 1'b1;
      idle_wait();
      // Low-going pulse setting parks the pin high between pulses
      tout_pol_fall = 1'b1;
      tick(2);
      chk("low pulse idle", 1, 1, trig_pin_out);
      $display("test trigger out done");
      close_out();
   end
endmodule // wbc_burst_ctrl_test
`default_nettype wire
